// ### hw/ecr_pkg.sv
/*
  Shared constants and types of the expander connection routing block.
  Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
package ecr_pkg;

  // ----------------------------------------------------------------
  // Widths and defaults
  // ----------------------------------------------------------------
  localparam int ADDR_W = 64;
  localparam int RATE_W = 4;
  localparam int NUM_PHYS_DEF = 8;
  localparam int NUM_ENTRIES_DEF = 16;
  localparam int PORT_W_DEF = 4;
  localparam logic TBL_CONFIGURABLE = 1'b1;

  // ----------------------------------------------------------------
  // Link rate codes that count as operating
  // ----------------------------------------------------------------
  localparam logic [3:0] RATE_G1 = 4'h8;
  localparam logic [3:0] RATE_G2 = 4'h9;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ATTR_DIRECT = 2'h0,
    ATTR_SUBTR = 2'h1,
    ATTR_TABLE = 2'h2
  } ecr_attr_t;

  typedef enum logic [1:0] {
    METH_DIRECT = 2'h0,
    METH_SUBTR = 2'h1,
    METH_TABLE = 2'h2,
    METH_NONE = 2'h3
  } ecr_meth_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DECIDE = 3'b010,
    ST_ANSWER = 3'b100
  } ecr_state_t;

endpackage

// ### hw/ecr_route_table.sv
/*
  Expander route table: entries of destination address and phy index,
  a management read/write port and a per-phy lookup hit vector.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module ecr_route_table import ecr_pkg::*; #(
  parameter int NUM_ENTRIES = NUM_ENTRIES_DEF,
  parameter int NUM_PHYS = NUM_PHYS_DEF,
  parameter int IW = $clog2(NUM_ENTRIES),
  parameter int PW = $clog2(NUM_PHYS)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Management access
  input wire logic mgmt_valid_i,
  input wire logic mgmt_write_i,
  input wire logic [IW-1:0] mgmt_index_i,
  input wire logic [ADDR_W-1:0] mgmt_addr_i,
  input wire logic [PW-1:0] mgmt_phy_i,
  input wire logic mgmt_disable_i,
  output logic mgmt_ack_o,
  output logic [ADDR_W-1:0] mgmt_rd_addr_o,
  output logic [PW-1:0] mgmt_rd_phy_o,
  output logic mgmt_rd_disable_o,
  // Lookup
  input wire logic [ADDR_W-1:0] lookup_addr_i,
  output logic [NUM_PHYS-1:0] lookup_hit_o
);

  typedef struct packed {
    logic [NUM_ENTRIES-1:0][ADDR_W-1:0] addr;
    logic [NUM_ENTRIES-1:0][PW-1:0] phy;
    logic [NUM_ENTRIES-1:0] en;
    logic ack;
    logic [ADDR_W-1:0] rd_addr;
    logic [PW-1:0] rd_phy;
    logic rd_dis;
  } ecr_rt_state_t;

  ecr_rt_state_t s_q;
  ecr_rt_state_t s_d;

  // ----------------------------------------------------------------
  // Management access
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    if (mgmt_valid_i) begin
      s_d.ack = 1'b1;
      if (mgmt_write_i) begin
        s_d.addr[mgmt_index_i] = mgmt_addr_i;
        s_d.phy[mgmt_index_i] = mgmt_phy_i;
        s_d.en[mgmt_index_i] = ~mgmt_disable_i;
      end else begin
        s_d.rd_addr = s_q.addr[mgmt_index_i];
        s_d.rd_phy = s_q.phy[mgmt_index_i];
        s_d.rd_dis = ~s_q.en[mgmt_index_i];
      end
    end
  end

  // All entries leave reset disabled
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Lookup
  // ----------------------------------------------------------------
  always_comb begin
    lookup_hit_o = '0;
    for (int e = 0; e < NUM_ENTRIES; e++) begin
      // Disabled entries never hit
      if (s_q.en[e] && (s_q.addr[e] == lookup_addr_i)) begin
        lookup_hit_o[s_q.phy[e]] = 1'b1;
      end
    end
  end

  assign mgmt_ack_o = s_q.ack;
  assign mgmt_rd_addr_o = s_q.rd_addr;
  assign mgmt_rd_phy_o = s_q.rd_phy;
  assign mgmt_rd_disable_o = s_q.rd_dis;

endmodule

// ### hw/ecr_router.sv
/*
  Routing decision of the expander connection manager: picks a
  destination phy for each connection request or rejects it.
  Assumes per-phy status inputs steady while a request is decided.
*/
`timescale 1ns/1ps
module ecr_router import ecr_pkg::*; #(
  parameter int NUM_PHYS = NUM_PHYS_DEF,
  parameter int NUM_ENTRIES = NUM_ENTRIES_DEF,
  parameter int PORT_W = PORT_W_DEF,
  parameter int PW = $clog2(NUM_PHYS),
  parameter int IW = $clog2(NUM_ENTRIES)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Per-phy status, phy i at slice i
  input wire logic [NUM_PHYS*2-1:0] phy_attr_i,
  input wire logic [NUM_PHYS*ADDR_W-1:0] phy_attached_addr_i,
  input wire logic [NUM_PHYS-1:0] phy_attached_exp_i,
  input wire logic [NUM_PHYS*PORT_W-1:0] phy_port_i,
  input wire logic [NUM_PHYS-1:0] phy_enabled_i,
  input wire logic [NUM_PHYS*RATE_W-1:0] phy_rate_i,
  input wire logic is_fanout_i,
  // Connection request
  input wire logic req_valid_i,
  input wire logic [PW-1:0] req_src_phy_i,
  input wire logic [ADDR_W-1:0] req_dest_addr_i,
  output logic req_ready_o,
  // Routing answer
  output logic resp_valid_o,
  output logic resp_reject_o,
  output logic [PW-1:0] resp_phy_o,
  output logic [1:0] resp_method_o,
  // Configuration checks
  output logic cfg_error_o,
  output logic sub_mismatch_o,
  // General report
  output logic [15:0] tbl_entries_o,
  output logic tbl_configurable_o,
  // Route table management
  input wire logic mgmt_valid_i,
  input wire logic mgmt_write_i,
  input wire logic [IW-1:0] mgmt_index_i,
  input wire logic [ADDR_W-1:0] mgmt_addr_i,
  input wire logic [PW-1:0] mgmt_phy_i,
  input wire logic mgmt_disable_i,
  output logic mgmt_ack_o,
  output logic [ADDR_W-1:0] mgmt_rd_addr_o,
  output logic [PW-1:0] mgmt_rd_phy_o,
  output logic mgmt_rd_disable_o
);

  typedef struct packed {
    ecr_state_t st;
    logic [PW-1:0] src;
    logic [PORT_W-1:0] src_port;
    logic [ADDR_W-1:0] dest;
    logic rej;
    logic [PW-1:0] phy;
    ecr_meth_t meth;
    logic cfg_err;
    logic mismatch;
  } ecr_main_t;

  localparam ecr_main_t S_RST = '{st: ST_IDLE, meth: METH_NONE, default: '0};

  ecr_main_t s_q;
  ecr_main_t s_d;

  logic [NUM_PHYS-1:0] tbl_hit;
  logic [NUM_PHYS-1:0] elig;
  logic [NUM_PHYS-1:0] other;
  logic [NUM_PHYS-1:0] dir_raw;
  logic [NUM_PHYS-1:0] tbl_raw;
  logic [NUM_PHYS-1:0] sub_raw;
  logic [NUM_PHYS-1:0] dir_ok;
  logic [NUM_PHYS-1:0] tbl_ok;
  logic [NUM_PHYS-1:0] sub_ok;
  logic [NUM_PHYS-1:0] sub_attr;
  logic cfg_err_now;
  logic mismatch_now;
  logic [PW-1:0] dir_pick;
  logic [PW-1:0] tbl_pick;
  logic [PW-1:0] sub_pick;
  logic pick_elig;
  logic pick_other;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [PW-1:0] first_idx(input logic [NUM_PHYS-1:0] m);
    logic [PW-1:0] r;
    r = '0;
    for (int k = NUM_PHYS - 1; k >= 0; k--) begin
      if (m[k]) begin
        r = PW'(k);
      end
    end
    return r;
  endfunction

  function automatic logic rate_ok(input logic [RATE_W-1:0] r);
    return (r == RATE_G1) || (r == RATE_G2);
  endfunction

  function automatic logic [1:0] attr_of(input int i);
    return phy_attr_i[i*2 +: 2];
  endfunction

  // ----------------------------------------------------------------
  // Route table
  // ----------------------------------------------------------------
  ecr_route_table #(
    .NUM_ENTRIES(NUM_ENTRIES),
    .NUM_PHYS(NUM_PHYS),
    .IW(IW),
    .PW(PW)
  ) u_table (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .mgmt_valid_i(mgmt_valid_i),
    .mgmt_write_i(mgmt_write_i),
    .mgmt_index_i(mgmt_index_i),
    .mgmt_addr_i(mgmt_addr_i),
    .mgmt_phy_i(mgmt_phy_i),
    .mgmt_disable_i(mgmt_disable_i),
    .mgmt_ack_o(mgmt_ack_o),
    .mgmt_rd_addr_o(mgmt_rd_addr_o),
    .mgmt_rd_phy_o(mgmt_rd_phy_o),
    .mgmt_rd_disable_o(mgmt_rd_disable_o),
    .lookup_addr_i(s_q.dest),
    .lookup_hit_o(tbl_hit)
  );

  assign tbl_entries_o = 16'(NUM_ENTRIES);
  assign tbl_configurable_o = TBL_CONFIGURABLE;

  // ----------------------------------------------------------------
  // Candidate masks per priority level
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_PHYS; i++) begin
      elig[i] = phy_enabled_i[i] && rate_ok(phy_rate_i[i*RATE_W +: RATE_W]);
      other[i] = phy_port_i[i*PORT_W +: PORT_W] != s_q.src_port;
      // Direct, table and subtractive-to-end phys route on attached address
      dir_raw[i] = elig[i]
        && (phy_attached_addr_i[i*ADDR_W +: ADDR_W] == s_q.dest)
        && ((attr_of(i) == ATTR_DIRECT)
          || (attr_of(i) == ATTR_TABLE)
          || ((attr_of(i) == ATTR_SUBTR) && !phy_attached_exp_i[i]));
      tbl_raw[i] = elig[i] && (attr_of(i) == ATTR_TABLE)
        && phy_attached_exp_i[i] && tbl_hit[i];
      sub_raw[i] = elig[i] && (attr_of(i) == ATTR_SUBTR)
        && phy_attached_exp_i[i];
      sub_attr[i] = attr_of(i) == ATTR_SUBTR;
    end
    dir_ok = dir_raw & other;
    tbl_ok = tbl_raw & other;
    sub_ok = sub_raw & other;
  end

  // Lowest phy index wins within a level
  assign dir_pick = first_idx(dir_ok);
  assign tbl_pick = first_idx(tbl_ok);
  assign sub_pick = first_idx(sub_ok);

  // Chosen phy as seen in the deciding cycle
  assign pick_elig = elig[s_d.phy];
  assign pick_other = other[s_d.phy];

  // ----------------------------------------------------------------
  // Configuration checks
  // ----------------------------------------------------------------
  always_comb begin
    logic [PW-1:0] f;
    f = first_idx(sub_attr);
    cfg_err_now = is_fanout_i && (|sub_attr);
    mismatch_now = 1'b0;
    for (int i = 0; i < NUM_PHYS; i++) begin
      // Subtractive phys spread over more than one port
      if (sub_attr[i]
          && (phy_port_i[i*PORT_W +: PORT_W] != phy_port_i[f*PORT_W +: PORT_W])) begin
        cfg_err_now = 1'b1;
      end
      if (sub_attr[i] && phy_attached_exp_i[i] && sub_attr[f] && phy_attached_exp_i[f]
          && (phy_attached_addr_i[i*ADDR_W +: ADDR_W]
            != phy_attached_addr_i[f*ADDR_W +: ADDR_W])) begin
        mismatch_now = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Decision sequence
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.cfg_err = cfg_err_now;
    s_d.mismatch = mismatch_now;
    case (s_q.st)
      ST_IDLE: begin
        if (req_valid_i) begin
          s_d.src = req_src_phy_i;
          s_d.src_port = phy_port_i[req_src_phy_i*PORT_W +: PORT_W];
          s_d.dest = req_dest_addr_i;
          s_d.st = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        s_d.rej = 1'b0;
        s_d.phy = '0;
        s_d.meth = METH_NONE;
        s_d.st = ST_ANSWER;
        if (|dir_raw) begin
          s_d.rej = ~|dir_ok;
          s_d.phy = dir_pick;
          s_d.meth = (|dir_ok) ? METH_DIRECT : METH_NONE;
        end else if (|tbl_raw) begin
          s_d.rej = ~|tbl_ok;
          s_d.phy = tbl_pick;
          s_d.meth = (|tbl_ok) ? METH_TABLE : METH_NONE;
        end else if (|sub_raw) begin
          s_d.rej = ~|sub_ok;
          s_d.phy = sub_pick;
          s_d.meth = (|sub_ok) ? METH_SUBTR : METH_NONE;
        end else begin
          s_d.rej = 1'b1;
        end
      end
      ST_ANSWER: begin
        s_d.st = ST_IDLE;
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= S_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign req_ready_o = s_q.st == ST_IDLE;
  assign resp_valid_o = s_q.st == ST_ANSWER;
  assign resp_reject_o = s_q.rej;
  assign resp_phy_o = s_q.phy;
  assign resp_method_o = s_q.meth;
  assign cfg_error_o = s_q.cfg_err;
  assign sub_mismatch_o = s_q.mismatch;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_answer_two_cycles: assert property (
    req_valid_i && req_ready_o |-> ##1 !resp_valid_o ##1 resp_valid_o ##1 !resp_valid_o)
    else $error("answer not two cycles after request");

  a_reject_no_match: assert property (
    (s_q.st == ST_DECIDE) && !(|(dir_raw | tbl_raw | sub_raw))
      |=> resp_valid_o && resp_reject_o)
    else $error("unroutable request not rejected");

  a_direct_first: assert property (
    (s_q.st == ST_DECIDE) && (|dir_ok)
      |=> !resp_reject_o && (resp_method_o == METH_DIRECT)
        && (resp_phy_o == $past(dir_pick)))
    else $error("attached address match not taken first");

  a_same_port_rej: assert property (
    (s_q.st == ST_DECIDE) && (|dir_raw) && !(|dir_ok) |=> resp_reject_o)
    else $error("match only in source port not rejected");

  a_table_second: assert property (
    (s_q.st == ST_DECIDE) && !(|dir_raw) && (|tbl_ok)
      |=> (resp_method_o == METH_TABLE) && (resp_phy_o == $past(tbl_pick)))
    else $error("table match not taken second");

  a_sub_third: assert property (
    (s_q.st == ST_DECIDE) && !(|(dir_raw | tbl_raw)) && (|sub_ok)
      |=> (resp_method_o == METH_SUBTR) && !resp_reject_o
        && (resp_phy_o == $past(sub_pick)))
    else $error("subtractive route not taken third");

  a_dest_usable: assert property (
    resp_valid_o && !resp_reject_o |-> $past(pick_elig))
    else $error("routed to disabled or idle phy");

  a_other_port_only: assert property (
    resp_valid_o && !resp_reject_o |-> $past(pick_other))
    else $error("routed into source port");

  a_reject_no_phy: assert property (
    resp_valid_o && resp_reject_o |-> (resp_method_o == METH_NONE) && (resp_phy_o == '0))
    else $error("reject carries a route");

  a_mgmt_ack_next: assert property (
    mgmt_valid_i |=> mgmt_ack_o)
    else $error("management access not acknowledged");

  a_sub_mismatch: assert property (
    mismatch_now |=> sub_mismatch_o)
    else $error("subtractive address mismatch not flagged");

  a_sub_attr_match: assert property (
    resp_valid_o && (resp_method_o == METH_SUBTR)
      |-> (phy_attr_i[resp_phy_o*2 +: 2] == ATTR_SUBTR) && phy_attached_exp_i[resp_phy_o])
    else $error("subtractive route on wrong phy");

  a_fanout_check: assert property (
    is_fanout_i && (|sub_attr) |=> cfg_error_o)
    else $error("fanout subtractive phy not flagged");

  c_direct_route: cover property (resp_valid_o && (resp_method_o == METH_DIRECT));
  c_table_route: cover property (resp_valid_o && (resp_method_o == METH_TABLE));
  c_sub_route: cover property (resp_valid_o && (resp_method_o == METH_SUBTR));
  c_reject: cover property (resp_valid_o && resp_reject_o);
  c_same_port: cover property ((s_q.st == ST_DECIDE) && (|dir_raw) && !(|dir_ok));

endmodule

// ### test/ecr_phy_model.sv
/*
  Far-side expander phys: status of each phy as the router sees it.
  Assumes the bench changes entries through set_phy between requests.
*/
`timescale 1ns/1ps
module ecr_phy_model import ecr_pkg::*; #(
  parameter int N = 8
) (
  // Per-phy status
  output logic [N*2-1:0] attr_o,
  output logic [N*ADDR_W-1:0] addr_o,
  output logic [N-1:0] exp_o,
  output logic [N*4-1:0] port_o,
  output logic [N-1:0] en_o,
  output logic [N*RATE_W-1:0] rate_o
);
  logic [1:0] attr [N];
  logic [63:0] addr [N];
  logic [3:0] port [N];
  logic [3:0] rate [N];
  logic [N-1:0] exp_q = '0;
  logic [N-1:0] en_q = '0;

  initial begin
    for (int i = 0; i < N; i++) begin
      attr[i] = 2'h0;
      addr[i] = 64'h0;
      port[i] = 4'h0;
      rate[i] = 4'h0;
    end
  end

  // One attribute held per phy
  task automatic set_phy(input int i, input logic [1:0] a, input logic [63:0] ad,
                         input logic x, input logic [3:0] p, input logic e,
                         input logic [3:0] r);
    attr[i] = a;
    addr[i] = ad;
    exp_q[i] = x;
    port[i] = p;
    en_q[i] = e;
    rate[i] = r;
  endtask

  always_comb begin
    for (int i = 0; i < N; i++) begin
      attr_o[2*i+:2] = attr[i];
      // Disabled phy shows no stale address
      addr_o[64*i+:64] = en_q[i] ? addr[i] : ~addr[i];
      port_o[4*i+:4] = port[i];
      rate_o[4*i+:4] = rate[i];
    end
    exp_o = exp_q;
    en_o = en_q;
  end
endmodule

// ### test/test_expander_connection_routing.sv
/*
  Self-checking bench of the routing decision block.
  Assumes the phy model drives status and the bench owns all else.
*/
`timescale 1ns/1ps
module test_expander_connection_routing import ecr_pkg::*; ;
  localparam logic [63:0] PA = 64'h5a00_0000_0000_0010;
  logic clk_i = 1'h0;
  logic arst_n_i = 1'h0;
  wire logic [15:0] attr_w;
  wire logic [511:0] addr_w;
  wire logic [7:0] exp_w;
  wire logic [31:0] port_w;
  wire logic [7:0] en_w;
  wire logic [31:0] rate_w;
  logic is_fanout_i = 1'h0;
  logic req_valid = 1'h0;
  logic [2:0] req_src = 3'h0;
  logic [63:0] req_dest = 64'h0;
  logic mv = 1'h0, mw = 1'h0, md = 1'h0;
  logic [3:0] mi = 4'h0;
  logic [63:0] ma = 64'h0;
  logic [2:0] mp = 3'h0;
  logic ready, rv, rr, cfg_e, sub_m, ack, rdd, tc;
  logic [2:0] rp, rdp;
  logic [1:0] rm;
  logic [15:0] te;
  logic [63:0] rda;
  logic [63:0] t_addr [16];
  logic [2:0] t_phy [16];
  logic t_dis [16];
  bit t_known [16];
  int err_total = 0;
  int checks_done = 0;
  int seed = 32'h2557;
  int s_l [10] = '{4, 0, 1, 0, 0, 2, 0, 0, 2, 0};
  int o_l [10] = '{0, 1, 1, 8, 9, 9, 10, 4, 4, 5};

  always #25 clk_i = ~clk_i;

  ecr_phy_model #(.N(8)) ecr_phy_model_i (.attr_o(attr_w), .addr_o(addr_w), .exp_o(exp_w),
    .port_o(port_w), .en_o(en_w), .rate_o(rate_w));

  ecr_router ecr_router_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .phy_attr_i(attr_w),
    .phy_attached_addr_i(addr_w), .phy_attached_exp_i(exp_w), .phy_port_i(port_w),
    .phy_enabled_i(en_w), .phy_rate_i(rate_w), .is_fanout_i(is_fanout_i),
    .req_valid_i(req_valid), .req_src_phy_i(req_src), .req_dest_addr_i(req_dest),
    .req_ready_o(ready), .resp_valid_o(rv), .resp_reject_o(rr), .resp_phy_o(rp),
    .resp_method_o(rm), .cfg_error_o(cfg_e), .sub_mismatch_o(sub_m),
    .tbl_entries_o(te), .tbl_configurable_o(tc), .mgmt_valid_i(mv), .mgmt_write_i(mw),
    .mgmt_index_i(mi), .mgmt_addr_i(ma), .mgmt_phy_i(mp), .mgmt_disable_i(md),
    .mgmt_ack_o(ack), .mgmt_rd_addr_o(rda), .mgmt_rd_phy_o(rdp), .mgmt_rd_disable_o(rdd));

  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("ERROR %0t: got %h want %h", $time, seen, want);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  function automatic int rnd(input int n);
    int v;
    v = $random(seed);
    return int'(unsigned'(v) % unsigned'(n));
  endfunction

  // Candidate phy p at priority level lv for destination d
  function automatic bit cand(input int lv, input int p, input logic [63:0] d);
    logic [3:0] r;
    r = ecr_phy_model_i.rate[p];
    if (!ecr_phy_model_i.en_q[p] || (r != RATE_G1 && r != RATE_G2)) return 0;
    if (lv == 1) return ecr_phy_model_i.addr[p] == d &&
      (ecr_phy_model_i.attr[p] != ATTR_SUBTR || !ecr_phy_model_i.exp_q[p]);
    if (lv == 3) return ecr_phy_model_i.attr[p] == ATTR_SUBTR &&
      ecr_phy_model_i.exp_q[p];
    if (ecr_phy_model_i.attr[p] != ATTR_TABLE || !ecr_phy_model_i.exp_q[p]) return 0;
    for (int e = 0; e < 16; e++)
      if (!t_dis[e] && t_addr[e] == d && t_phy[e] == p) return 1;
    return 0;
  endfunction

  function automatic logic [5:0] expect_route(input int s, input logic [63:0] d);
    int pick;
    bit hit;
    logic [1:0] meth;
    pick = -1;
    hit = 0;
    meth = METH_NONE;
    for (int lv = 1; lv <= 3 && !hit; lv++) begin
      for (int p = 0; p < 8; p++) begin
        if (cand(lv, p, d)) begin
          hit = 1;
          if (ecr_phy_model_i.port[p] != ecr_phy_model_i.port[s] && pick < 0) begin
            pick = p;
            meth = (lv == 1) ? METH_DIRECT : (lv == 2) ? METH_TABLE : METH_SUBTR;
          end
        end
      end
    end
    return (pick < 0) ? {1'h1, 2'h3, 3'h0} : {1'h0, meth, 3'(pick)};
  endfunction

  task automatic do_req(input int s, input logic [63:0] d);
    logic [5:0] e;
    int n;
    e = expect_route(s, d);
    n = 0;
    @(negedge clk_i);
    req_valid = 1'h1;
    req_src = 3'(s);
    req_dest = d;
    @(negedge clk_i);
    req_valid = 1'h0;
    check(ready, 1'h0);
    while (rv !== 1'h1 && n < 4) begin
      @(negedge clk_i);
      n++;
    end
    check(64'(n), 64'h1);
    check({rr, rm, rp}, e);
    @(negedge clk_i);
    check({rv, ready}, 2'h1);
  endtask

  task automatic mgmt(input logic w, input int i, input logic [63:0] a,
                      input logic [2:0] p, input logic dis);
    @(negedge clk_i);
    mv = 1'h1;
    mw = w;
    mi = 4'(i);
    ma = a;
    mp = p;
    md = dis;
    if (w) begin
      t_addr[i] = a;
      t_phy[i] = p;
      t_dis[i] = dis;
      t_known[i] = 1;
    end
    @(negedge clk_i);
    mv = 1'h0;
    check(ack, 1'h1);
    if (!w) check(rdd, t_dis[i]);
    if (!w && t_known[i]) check({rdp, rda}, {t_phy[i], t_addr[i]});
  endtask

  initial begin
    for (int e = 0; e < 16; e++) t_dis[e] = 1'h1;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    check({ready, rv, rm}, 4'hb);
    arst_n_i = 1'h1;
    check({te, tc}, {16'h10, 1'h1});
    for (int e = 0; e < 16; e++) mgmt(1'h0, e, 64'h0, 3'h0, 1'h0);
    ecr_phy_model_i.set_phy(0, ATTR_DIRECT, PA, 1'h0, 4'h0, 1'h1, 4'h8);
    ecr_phy_model_i.set_phy(1, ATTR_TABLE, PA + 1, 1'h1, 4'h1, 1'h1, 4'h9);
    ecr_phy_model_i.set_phy(2, ATTR_SUBTR, PA + 2, 1'h1, 4'h2, 1'h1, 4'h8);
    ecr_phy_model_i.set_phy(3, ATTR_SUBTR, PA + 2, 1'h1, 4'h2, 1'h1, 4'h9);
    ecr_phy_model_i.set_phy(4, ATTR_TABLE, PA + 3, 1'h0, 4'h3, 1'h1, 4'h8);
    ecr_phy_model_i.set_phy(5, ATTR_DIRECT, PA + 4, 1'h1, 4'h4, 1'h1, 4'h8);
    ecr_phy_model_i.set_phy(6, ATTR_TABLE, PA + 1, 1'h1, 4'h1, 1'h0, 4'h8);
    ecr_phy_model_i.set_phy(7, ATTR_TABLE, PA + 5, 1'h1, 4'h5, 1'h1, 4'h0);
    mgmt(1'h1, 0, PA + 8, 3'h1, 1'h0);
    mgmt(1'h1, 1, PA + 9, 3'h1, 1'h1);
    mgmt(1'h1, 2, PA + 10, 3'h7, 1'h0);
    mgmt(1'h1, 3, PA + 8, 3'h2, 1'h0);
    for (int e = 0; e < 4; e++) mgmt(1'h0, e, 64'h0, 3'h0, 1'h0);
    for (int k = 0; k < 10; k++)
      do_req(s_l[k], (PA + o_l[k]) ^ ((k == 8) ? 64'h8000_0000_0000_0000 : 64'h0));
    check({cfg_e, sub_m}, 2'h0);
    ecr_phy_model_i.set_phy(3, ATTR_SUBTR, PA + 6, 1'h1, 4'h2, 1'h1, 4'h9);
    repeat (2) @(negedge clk_i);
    check(sub_m, 1'h1);
    ecr_phy_model_i.set_phy(3, ATTR_SUBTR, PA + 2, 1'h1, 4'h3, 1'h1, 4'h9);
    repeat (2) @(negedge clk_i);
    check({cfg_e, sub_m}, 2'h2);
    ecr_phy_model_i.set_phy(3, ATTR_SUBTR, PA + 2, 1'h1, 4'h2, 1'h1, 4'h9);
    is_fanout_i = 1'h1;
    repeat (2) @(negedge clk_i);
    check(cfg_e, 1'h1);
    is_fanout_i = 1'h0;
    // Reset in mid-run clears every route entry
    @(negedge clk_i);
    arst_n_i = 1'h0;
    @(negedge clk_i);
    check({ready, rv, rm, ack}, 5'h16);
    arst_n_i = 1'h1;
    for (int e = 0; e < 16; e++) begin
      t_dis[e] = 1'h1;
      t_known[e] = 0;
    end
    for (int e = 0; e < 4; e++) mgmt(1'h0, e, 64'h0, 3'h0, 1'h0);
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 8; i++)
        ecr_phy_model_i.set_phy(i, 2'(rnd(3)), PA + rnd(4), 1'(rnd(2)), 4'(rnd(4)),
          rnd(4) != 0, (rnd(4) == 0) ? 4'(rnd(16)) : 4'h8 + 4'(rnd(2)));
      for (int e = 0; e < 16; e++) mgmt(1'h1, e, PA + 8 + rnd(4), 3'(rnd(8)), rnd(3) == 0);
      for (int e = 0; e < 16; e++) mgmt(1'h0, e, 64'h0, 3'h0, 1'h0);
      for (int k = 0; k < 40; k++)
        do_req(rnd(8), (rnd(5) == 0) ? {$random(seed), $random(seed)} : PA + rnd(12));
    end
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    finish_test();
  end
endmodule
